// ===== logic/srtc_pkg.sv
// Package for the socket timekeeper: field layout, reset values, timing counts.
// Assumes a single 100 MHz clock domain.
package srtc_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          TICK_MS        = 10;
  localparam int          TICK_CYC       = TICK_MS * 1000 * CLK_MHZ;
  localparam int          NREG           = 8;
  localparam int          NBITS          = 64;
  localparam logic [63:0] KEY_DEFAULT    = 64'h5CA33AC55CA33AC5;
  localparam int          IDX_CENTI      = 0;
  localparam int          IDX_SEC        = 1;
  localparam int          IDX_MIN        = 2;
  localparam int          IDX_HOUR       = 3;
  localparam int          IDX_DOW        = 4;
  localparam int          IDX_DATE       = 5;
  localparam int          IDX_MONTH      = 6;
  localparam int          IDX_YEAR       = 7;
  localparam int          HOUR_MODE_BIT  = 7;
  localparam int          HOUR_PM_BIT    = 5;
  localparam int          DOW_ABORT_DIS  = 4;
  localparam int          DOW_OSC_STOP   = 5;
  localparam logic [7:0]  DOW_RESET      = 8'h31;
  localparam logic [7:0]  DATE_RESET     = 8'h01;
  localparam logic [7:0]  MONTH_RESET    = 8'h01;
  localparam logic [63:0] READ_MASK      = 64'hFF_1F_3F_37_BF_7F_7F_FF;
  localparam logic [5:0]  LAST_BIT       = 6'h3F;

  // State codes for MATCH and DEAD differ in one bit; MATCH and XFER differ in both
  typedef enum logic [1:0] {
    SRTC_MATCH = 2'b00,
    SRTC_DEAD  = 2'b01,
    SRTC_XFER  = 2'b11
  } srtc_state_e;

  // One completed socket cycle
  typedef struct packed {
    logic rd;
    logic din;
  } srtc_cyc_s;
endpackage : srtc_pkg

// ===== logic/srtc_top.sv
// Timekeeper living in a memory socket, reached only through read cycles.
// Assumes socket strobes are synchronous to clk and stay low for two clocks or more.
`timescale 1ns/100ps

// Small FIFO with valid/ready on both sides.
module srtc_fifo #(
  parameter int W = 2,
  parameter int D = 4
) (
  input  wire logic         clk,      // Clock
  input  wire logic         srst,     // Sync reset
  input  wire logic [W-1:0] in_data,  // Write data
  input  wire logic         in_valid, // Write request
  output logic              in_ready, // Not full
  output logic [W-1:0]      out_data, // Head word
  output logic              out_valid,// Not empty
  input  wire logic         out_ready // Pop
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  cnt_r;
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic push;
  logic pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_r];

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end
endmodule : srtc_fifo

// Contract
// (R1) Registers open only after a 64-bit key sent as 64 write cycles.
// (R2) Select line low means write; bit taken from data-in address line.
// (R3) Select line high means read; one bit driven on the data-out line.
// (R4) Host uses only read cycles to the socket, never processor writes.
// (R5) Cycle starts when either strobe falls, ends when either rises; both active. Here a cycle starts only once both strobes are low.
// (R6) Host issues one read before the key to restart the pointer.
// (R7) First key write is compared with bit 0; a match advances the pointer.
// (R8) A mismatch freezes the pointer and later writes are ignored.
// (R9) Any read during key matching aborts and resets the pointer.
// (R10) After the key, the next 64 cycles move register data by select level.
// (R11) Cycles outside the socket block do not disturb the sequence.
// (R12) Abort pin low when enabled, or power-up, resets pointer; data kept. Power-up (srst) here also reloads the registers.
// (R13) During transfer the memory select to the mated memory is blocked.
// (R14) All eight registers pass in one go, LSB of first to MSB of last.
// (R15) Counts hundredths to years at 10 ms; month lengths and leap years.
// (R16) All time values are held in BCD.
// (R17) Hour bit 7 high picks 12-hour mode; bit 5 is PM or tens-of-hours.
// (R18) Day bit 4 set ignores the abort pin; clear lets it abort transfers.
// (R19) Day bit 5 set stops the oscillator; clear lets the counters run.
// (R20) Both day control bits are one in the initial state.
// (R21) Unused bits of registers 1 to 6 read zero; any written value accepted.
// (R22) Power-fail ignores inputs and aborts like the abort pin.
// (R23) The key is a parameter defaulting to C5 3A A3 5C twice, LSB first.
module srtc_top
  import srtc_pkg::*;
#(
  parameter logic [63:0] KEY      = KEY_DEFAULT, // see (R23)
  parameter int          TICK_CNT = TICK_CYC     // Cycles per hundredth
) (
  input  wire logic clk,           // 100 MHz clock
  input  wire logic srst,          // Sync reset, also the power-up event
  input  wire logic sock_sel_n,    // Socket memory select, active low
  input  wire logic sock_rd_n,     // Socket read strobe, active low
  input  wire logic rw_select_addr,// High read, low write
  input  wire logic data_in_addr,  // Serial write data bit
  input  wire logic abort_addr_n,  // Abort pin, active low
  input  wire logic power_fail,    // Supply out of tolerance
  output logic      mem_sel_n,     // Select passed to mated memory
  output logic      data_out_line, // Serial read bit
  output logic      data_out_oe,   // Drive enable for the read bit
  output logic      busy           // Transfer window open
);
  logic [7:0]  regs_r [NREG];
  srtc_state_e state_r;
  logic [5:0]  ptr_r;
  logic        act_r;
  logic        out_bit_r;
  logic        act_now;
  logic        cyc_end;
  logic        abort;
  logic        pop;
  logic        fifo_in_ready;
  logic        fifo_valid;
  srtc_cyc_s   cyc_in;
  srtc_cyc_s   cyc;
  logic [63:0] flat;
  logic [63:0] wr_img_r;
  logic        commit;
  logic        tick;
  logic [31:0] tick_r;
  logic        cyc_rd_r;
  logic        cyc_din_r;

  // Cycle is live only while both strobes are low; ends on first rise
  assign act_now = !sock_sel_n && !sock_rd_n;            // see (R5)
  assign cyc_end = act_r && !act_now;                    // see (R5) (R11)
  // Abort pin honoured only when the day control bit is clear
  assign abort   = power_fail ||
                   (!abort_addr_n && !regs_r[IDX_DOW][DOW_ABORT_DIS]); // see (R12) (R18) (R22)
  // Address lines may move as soon as the strobes rise, so the cycle's
  // meaning is taken from the last clock at which it was still live
  assign cyc_in  = '{rd: cyc_rd_r, din: cyc_din_r};      // see (R2) (R3)

  // Strobe edge tracker; power-fail blocks inputs
  always_ff @(posedge clk) begin
    if (srst) act_r <= 1'b0;
    else      act_r <= act_now && !power_fail;           // see (R22)
  end

  // Select and data-in lines sampled while the cycle is live, held once it ends
  always_ff @(posedge clk) begin
    if (srst) begin
      cyc_rd_r  <= 1'b1;
      cyc_din_r <= 1'b0;
    end else if (act_now) begin
      cyc_rd_r  <= rw_select_addr;                       // see (R2) (R3)
      cyc_din_r <= data_in_addr;                         // see (R2)
    end
  end

  // Cycles queue in order; a full queue drops the cycle, which only a
  // host far faster than the queue drains could ever cause
  srtc_fifo #(.W(2), .D(4)) u_fifo (
    .clk      (clk),
    .srst     (srst || abort),
    .in_data  (cyc_in),
    .in_valid (cyc_end),
    .in_ready (fifo_in_ready),
    .out_data (cyc),
    .out_valid(fifo_valid),
    .out_ready(1'b1)
  );
  assign pop = fifo_valid;

  // Flattened register image, unused bits forced to zero on readout
  for (genvar g = 0; g < NREG; g++) begin : g_flat
    assign flat[8*g +: 8] = regs_r[g] & READ_MASK[8*g +: 8]; // see (R21)
  end

  // Key matcher and transfer sequencer
  always_ff @(posedge clk) begin
    if (srst || abort) begin
      state_r <= SRTC_MATCH;                             // see (R12)
      ptr_r   <= '0;
    end else if (pop) begin
      case (state_r)
        SRTC_MATCH: begin
          if (cyc.rd) begin
            ptr_r <= '0;                                 // see (R9) (R6)
          end else if (cyc.din == KEY[ptr_r]) begin      // see (R7) (R1)
            ptr_r <= ptr_r + 1'b1;
            if (ptr_r == LAST_BIT) state_r <= SRTC_XFER;
          end else begin
            state_r <= SRTC_DEAD;                        // see (R8)
          end
        end
        SRTC_DEAD: begin
          if (cyc.rd) begin
            state_r <= SRTC_MATCH;                       // see (R9)
            ptr_r   <= '0;
          end
        end
        SRTC_XFER: begin
          ptr_r <= ptr_r + 1'b1;                         // see (R10) (R14)
          if (ptr_r == LAST_BIT) state_r <= SRTC_MATCH;
        end
        default: state_r <= SRTC_MATCH;
      endcase
    end
  end

  // Write image gathered bit by bit; committed only after bit 63
  always_ff @(posedge clk) begin
    if (srst) wr_img_r <= '0;
    else if (pop && state_r == SRTC_XFER && !cyc.rd && !abort)
      wr_img_r[ptr_r] <= cyc.din;                        // see (R10) (R14)
  end
  assign commit = pop && !abort && state_r == SRTC_XFER && ptr_r == LAST_BIT && !cyc.rd;

  // Read bit launched during the cycle from the current pointer
  always_ff @(posedge clk) begin
    if (srst) out_bit_r <= 1'b0;
    else      out_bit_r <= flat[ptr_r];                  // see (R3) (R14)
  end
  assign busy          = (state_r == SRTC_XFER);
  assign data_out_oe   = busy && act_now && rw_select_addr; // see (R3)
  assign data_out_line = out_bit_r;
  assign mem_sel_n     = sock_sel_n || busy;             // see (R13)

  // Hundredth tick, held while oscillator stop bit is set
  always_ff @(posedge clk) begin
    if (srst || regs_r[IDX_DOW][DOW_OSC_STOP]) tick_r <= '0; // see (R19)
    else if (tick)                              tick_r <= '0;
    else                                        tick_r <= tick_r + 32'h1;
  end
  assign tick = (tick_r == 32'(TICK_CNT - 1));           // see (R15)

  // BCD increment helper with wrap limit and restart value
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] lo);
    logic [7:0] n;
    n = v;
    if (v == top)          return {1'b1, lo};
    if (v[3:0] == 4'h9)    n = {v[7:4] + 4'h1, 4'h0};
    else                   n = {v[7:4], v[3:0] + 4'h1};
    return {1'b0, n};
  endfunction : bcd_inc

  // Days in month, BCD, with leap years for year divisible by four
  function automatic logic [7:0] month_top(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = ((y[7:4] * 8'hA + {4'h0, y[3:0]}) % 8'h4) == 8'h0;
    case (m)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction : month_top

  // Hour step for both modes; returns carry into date
  function automatic logic [8:0] hour_inc(input logic [7:0] h);
    logic [4:0] v;
    v = h[4:0];
    if (h[HOUR_MODE_BIT]) begin                          // see (R17)
      if (v == 5'h12) return {1'b0, h[7:5], 5'h01};
      if (v == 5'h11) return {h[HOUR_PM_BIT], h[7:6], !h[HOUR_PM_BIT], 5'h12};
      if (v == 5'h09) return {1'b0, h[7:5], 5'h10};
      return {1'b0, h[7:5], v + 5'h01};
    end
    if (h[5:0] == 6'h23) return {1'b1, h[7:6], 6'h00};   // see (R17)
    if (h[3:0] == 4'h9)  return {1'b0, h[7:6], h[5:4] + 2'h1, 4'h0};
    return {1'b0, h[7:4], h[3:0] + 4'h1};
  endfunction : hour_inc

  // Time counters; a committed write replaces all eight registers at once
  always_ff @(posedge clk) begin
    logic [8:0] r0, r1, r2, r3, r5, r6, r7;
    r0 = '0; r1 = '0; r2 = '0; r3 = '0; r5 = '0; r6 = '0; r7 = '0;
    if (srst) begin
      for (int i = 0; i < NREG; i++) regs_r[i] <= 8'h00;
      regs_r[IDX_DOW]   <= DOW_RESET;                    // see (R20)
      regs_r[IDX_DATE]  <= DATE_RESET;
      regs_r[IDX_MONTH] <= MONTH_RESET;
    end else if (commit) begin
      for (int i = 0; i < NREG; i++)
        regs_r[i] <= wr_img_r[8*i +: 8] | ({7'h0, cyc.din} << (i == 7 ? 7 : 8)); // see (R14)
      regs_r[IDX_YEAR] <= {cyc.din, wr_img_r[62:56]};
    end else if (tick) begin                             // see (R15) (R16)
      r0 = bcd_inc(regs_r[IDX_CENTI], 8'h99, 8'h00);
      regs_r[IDX_CENTI] <= r0[7:0];
      if (r0[8]) begin
        r1 = bcd_inc(regs_r[IDX_SEC], 8'h59, 8'h00);
        regs_r[IDX_SEC] <= r1[7:0];
      end
      if (r1[8]) begin
        r2 = bcd_inc(regs_r[IDX_MIN], 8'h59, 8'h00);
        regs_r[IDX_MIN] <= r2[7:0];
      end
      if (r2[8]) begin
        r3 = hour_inc(regs_r[IDX_HOUR]);
        regs_r[IDX_HOUR] <= r3[7:0];
      end
      if (r3[8]) begin
        regs_r[IDX_DOW][2:0] <= (regs_r[IDX_DOW][2:0] == 3'h7) ? 3'h1
                                : regs_r[IDX_DOW][2:0] + 3'h1;
        r5 = bcd_inc(regs_r[IDX_DATE], month_top(regs_r[IDX_MONTH], regs_r[IDX_YEAR]),
                     8'h01);
        regs_r[IDX_DATE] <= r5[7:0];
      end
      if (r5[8]) begin
        r6 = bcd_inc(regs_r[IDX_MONTH], 8'h12, 8'h01);
        regs_r[IDX_MONTH] <= r6[7:0];
      end
      if (r6[8]) begin
        r7 = bcd_inc(regs_r[IDX_YEAR], 8'h99, 8'h00);
        regs_r[IDX_YEAR] <= r7[7:0];
      end
    end
  end

  // Checks kept beside the logic
  property p_sel_block;
    @(posedge clk) disable iff (srst) busy |-> mem_sel_n;
  endproperty
  a_sel_block: assert property (p_sel_block) else $error("memory select not blocked"); // see (R13)

  property p_abort;
    @(posedge clk) disable iff (srst) abort |=> (ptr_r == 6'h00 && state_r == SRTC_MATCH);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not reset pointer"); // see (R12)

  property p_dead_hold;
    @(posedge clk) disable iff (srst)
      (state_r == SRTC_DEAD && !(pop && cyc.rd) && !abort) |=> state_r == SRTC_DEAD;
  endproperty
  a_dead_hold: assert property (p_dead_hold) else $error("dead state left on write"); // see (R8)

  property p_read_reset;
    @(posedge clk) disable iff (srst)
      (state_r != SRTC_XFER && pop && cyc.rd) |=> ptr_r == 6'h00;
  endproperty
  a_read_reset: assert property (p_read_reset) else $error("read did not reset pointer"); // see (R9)

  property p_match_step;
    @(posedge clk) disable iff (srst)
      (state_r == SRTC_MATCH && pop && !cyc.rd && cyc.din == KEY[ptr_r] && !abort)
      |=> ptr_r == $past(ptr_r) + 6'h01;
  endproperty
  a_match_step: assert property (p_match_step) else $error("pointer did not advance"); // see (R7)

  property p_unlock;
    @(posedge clk) disable iff (srst)
      (state_r == SRTC_MATCH && ptr_r == LAST_BIT && pop && !cyc.rd
       && cyc.din == KEY[63] && !abort) |=> busy;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock missed after 64 bits"); // see (R1)

  property p_osc_stop;
    @(posedge clk) disable iff (srst) regs_r[IDX_DOW][DOW_OSC_STOP] |=> !tick;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("tick while oscillator stopped"); // see (R19)

  property p_zero_bits;
    @(posedge clk) disable iff (srst) !READ_MASK[$past(ptr_r)] |-> !data_out_line;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bit reads one"); // see (R21)

  // A dropped cycle would silently shift every later bit
  property p_no_drop;
    @(posedge clk) disable iff (srst) cyc_end |-> fifo_in_ready;
  endproperty
  a_no_drop: assert property (p_no_drop) else $error("socket cycle dropped"); // see (R5)

  // Window closes right after the 64th transfer cycle
  property p_xfer_len;
    @(posedge clk) disable iff (srst)
      (state_r == SRTC_XFER && ptr_r == LAST_BIT && pop && !abort)
      |=> (state_r == SRTC_MATCH && ptr_r == 6'h00);
  endproperty
  a_xfer_len: assert property (p_xfer_len) else $error("transfer window length wrong"); // see (R10)

  // Low hundredths digit never leaves the decimal range by counting
  property p_centi_bcd;
    @(posedge clk) disable iff (srst)
      (tick && !commit && regs_r[IDX_CENTI][3:0] == 4'h9)
      |=> regs_r[IDX_CENTI][3:0] == 4'h0;
  endproperty
  a_centi_bcd: assert property (p_centi_bcd) else $error("hundredths digit not BCD"); // see (R16)

  // Counting never clears the 12-hour selection
  property p_hour_mode;
    @(posedge clk) disable iff (srst)
      (tick && !commit && regs_r[IDX_HOUR][HOUR_MODE_BIT])
      |=> regs_r[IDX_HOUR][HOUR_MODE_BIT];
  endproperty
  a_hour_mode: assert property (p_hour_mode) else $error("hour mode bit lost"); // see (R17)
endmodule : srtc_top

// ===== tb/srtc_host_model.sv
// Host model: makes socket read cycles that carry the key and the serial bits.
// Assumes the design clock; strobes stay low four clocks, high four.
`timescale 1ns/100ps
module srtc_host_model
  import srtc_pkg::*;
(
  input  wire logic clk,            // Design clock
  input  wire logic data_out_line,  // Serial read bit
  input  wire logic data_out_oe,    // Read bit drive enable
  input  wire logic mem_sel_n,      // Select seen by mated memory
  output logic      sock_sel_n,     // Socket select, active low
  output logic      sock_rd_n,      // Read strobe, active low
  output logic      rw_select_addr, // Address line: read or write
  output logic      data_in_addr    // Address line: write bit
);
  // Idle bus at time zero
  initial begin
    sock_sel_n = 1'b1;
    sock_rd_n = 1'b1;
    rw_select_addr = 1'b1;
    data_in_addr = 1'b0;
  end

  // One cycle; outputs are taken at the last edge before the strobes rise
  task automatic cycle(input logic rd, input logic din, input logic in_blk,
                       output logic [2:0] seen);
    begin
      @(posedge clk);
      sock_sel_n <= ~in_blk;
      sock_rd_n <= 1'b0;            // Only reads ever
      rw_select_addr <= rd;
      data_in_addr <= din;
      repeat (4) @(posedge clk);
      seen = {mem_sel_n, data_out_oe, data_out_line};
      sock_sel_n <= 1'b1;
      sock_rd_n <= 1'b1;
      rw_select_addr <= ~rd;        // Address lines move on once released
      data_in_addr <= ~din;
      repeat (3) @(posedge clk);
    end
  endtask : cycle

  // Restart read, then key bits; flip picks one bit to corrupt
  task automatic unlock(input int nbits, input int flip);
    logic [2:0] s;
    begin
      cycle(1'b1, 1'b0, 1'b1, s);
      for (int i = 0; i < nbits; i++) begin
        cycle(1'b0, KEY_DEFAULT[i] ^ (i == flip), 1'b1, s);
        if (i % 16 == 5) cycle(1'b1, 1'b0, 1'b0, s);
      end
    end
  endtask : unlock
endmodule : srtc_host_model

// ===== tb/tb.sv
// Bench: host model drives the socket; reads compared with a BCD register model.
// Assumes one hundredth every TICKS clocks, shortened for simulation.
`timescale 1ns/100ps
module tb;
  import srtc_pkg::*;
  localparam int TICKS = 2000;
  logic       clk, srst, abort_addr_n, power_fail, sock_sel_n, sock_rd_n;
  logic       rw_select_addr, data_in_addr, mem_sel_n, data_out_line, data_out_oe, busy;
  int         fails, total_checks, seed, n;
  int         lim [8] = '{100, 60, 60, 24, 7, 28, 12, 100};
  logic [7:0] exp_r [8], wr_r [8], got [8];
  // Written values and expected values after the rollover
  logic [7:0] roll [4][8] = '{
    '{8'h99, 8'h59, 8'h59, 8'h23, 8'h17, 8'h28, 8'h02, 8'h01},
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h01, 8'h03, 8'h01},
    '{8'h99, 8'h59, 8'h59, 8'hB1, 8'h13, 8'h28, 8'h02, 8'h04},
    '{8'h00, 8'h00, 8'h00, 8'h92, 8'h14, 8'h29, 8'h02, 8'h04}};

  srtc_top #(.TICK_CNT(TICKS)) dut (.clk(clk), .srst(srst), .sock_sel_n(sock_sel_n),
    .sock_rd_n(sock_rd_n), .rw_select_addr(rw_select_addr), .data_in_addr(data_in_addr),
    .abort_addr_n(abort_addr_n), .power_fail(power_fail), .mem_sel_n(mem_sel_n),
    .data_out_line(data_out_line), .data_out_oe(data_out_oe), .busy(busy));
  srtc_host_model host (.clk(clk), .data_out_line(data_out_line), .data_out_oe(data_out_oe),
    .mem_sel_n(mem_sel_n), .sock_sel_n(sock_sel_n), .sock_rd_n(sock_rd_n),
    .rw_select_addr(rw_select_addr), .data_in_addr(data_in_addr));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic tally_and_finish;
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Serial transfer of nb bits; foreign cycles woven in
  task automatic xfer(input logic rd, input int nb);
    logic [2:0] s;
    begin
      for (int i = 0; i < nb; i++) begin
        if (i % 24 == 7) host.cycle(1'b1, 1'b0, 1'b0, s);
        host.cycle(rd, wr_r[i / 8][i % 8], 1'b1, s);
        check({7'h0, s[2]}, 8'h01, "mem select");
        check({7'h0, s[1]}, {7'h0, rd}, "drive enable");
        got[i / 8][i % 8] = s[0];
      end
      @(negedge clk);
    end
  endtask : xfer

  task automatic read_all(input int from);
    begin
      host.unlock(64, -1);
      xfer(1'b1, 64);
      check({7'h0, busy}, 8'h00, "busy after 64");
      for (int r = from; r < 8; r++)
        check(got[r], exp_r[r], "register");
    end
  endtask : read_all

  task automatic write_all;
    begin
      host.unlock(64, -1);
      xfer(1'b0, 64);
    end
  endtask : write_all

  // Abort pin or supply failure held three clocks
  task automatic pulse(input logic pf, input logic busy_after);
    begin
      @(posedge clk);
      if (pf) power_fail <= 1'b1;
      else abort_addr_n <= 1'b0;
      repeat (3) @(posedge clk);
      power_fail <= 1'b0;
      abort_addr_n <= 1'b1;
      repeat (2) @(negedge clk);
      check({7'h0, busy}, {7'h0, busy_after}, "busy after abort");
    end
  endtask : pulse

  // Main sequence
  initial begin
    seed = 13;
    fails = 0;
    total_checks = 0;
    srst = 1'b1;
    abort_addr_n = 1'b1;
    power_fail = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    exp_r = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h01, 8'h01, 8'h00};
    read_all(0);
    for (int k = 0; k < 3; k++) begin
      // Random BCD contents, oscillator stopped, unused bits written with random values
      for (int r = 0; r < 8; r++) begin
        n = (r >= 4 && r <= 6) + ($unsigned($random(seed)) % lim[r]);
        exp_r[r] = (r == 4) ? 8'((k == 1 ? 8'h20 : 8'h30) | n) : bcd(n);
        wr_r[r] = exp_r[r] | (8'($random(seed)) & ~READ_MASK[r * 8 +: 8]);
      end
      write_all();
      if (k == 0) begin
        host.unlock(64, 5);
        check({7'h0, busy}, 8'h00, "busy after bad key");
        host.unlock(10, -1);
      end else begin
        host.unlock(64, -1);
        for (int r = 0; r < 8; r++) wr_r[r] = ~wr_r[r];
        xfer(1'b0, 20);                                     // Partial write, then abort
        pulse(1'b0, k == 2);
        if (k == 2) pulse(1'b1, 1'b0);
      end
      read_all(0);
    end
    // Rollover at midnight: plain year, then leap year in 12-hour mode
    for (int k = 0; k < 2; k++) begin
      wr_r = roll[2 * k];
      exp_r = roll[2 * k + 1];
      write_all();
      repeat (3000) @(posedge clk);                         // One or two hundredths pass
      read_all(1);
      check({7'h0, got[0] <= 8'h02}, 8'h01, "hundredths");
    end
    tally_and_finish();
  end

  // Watchdog, about three and a half times the expected run
  initial begin
    #700000;
    fails++;
    tally_and_finish();
  end
endmodule : tb
